// ==== lin_autobaud_uart_routing.sv ====
// LIN break and synch detector, capture timer, serial pin routing and completion flags
`include "lin_autobaud_defines.svh"
// How it works
// RULE1: The master sends a break of at least 13 low bits, synch 0x55, then identifier.
// RULE2: In capture mode the timer starts on a falling edge of the transceiver receive line.
// RULE3: Software picks a break range covering the master rate; 3 suits 40 MHz.
// RULE4: The break's falling edge starts the timer and sets the external event flag.
// RULE5: Software stops the timer, clears its count and disables its external event flag.
// RULE6: A stopped timer restarts on the next falling edge, the synch start bit.
// RULE7: While running, every falling edge copies the count into the capture register.
// RULE8: Break-seen is set only if the break lasted at least 11 first-bit times.
// RULE9: Synch-done is set after a valid synch byte and can request an interrupt.
// RULE10: Software checks break-seen and clears both flags through the flag clear register.
// RULE11: At synch-done the capture register holds the count from the eighth synch bit.
// RULE12: A malformed synch byte sets synch-error instead of synch-done.
// RULE13: Software re-enables the timer event flag by frame end or on synch error.
// RULE14: Mode 0 shifts on receive and shift data out, shift clock on transmit.
// RULE15: Modes 1 to 3 transmit on the transmit line and receive on receive.
// RULE16: Select 0, disconnect 0: port to transceiver, optionally mirrored on the GPIOs.
// RULE17: Disconnect 1: GPIO input drives transceiver transmit, its receive drives GPIO and port.
// RULE18: Select 1, disconnect 0: transmit on GPIO and transceiver, receive from GPIO.
// RULE19: Standalone routing drops transmit to recessive after the dominant timeout.
// RULE20: Receive and transmit complete flags each have their own interrupt enable.
// RULE21: A pin select bit chooses the second port's receive and transmit pins.
// RULE22: Software pulses the break logic reset and clears all three flags first.
// RULE23: Detector samples at clock over 8 times 2^range; 4095 samples overflow to error.
// RULE24: Break, synch-done and synch-error stay set until cleared, and reset to 0.
// RULE25: Both routing select bits reset to 0, port connected to the transceiver.
module lin_autobaud_uart_routing #(
	parameter int DOM_TIMEOUT_CYC = `DOM_TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial core side, same clock
	input  wire logic        coreTxd,
	input  wire logic        shiftClk,
	input  wire logic        shiftData,
	input  wire logic        rxDoneEvt,
	input  wire logic        txDoneEvt,
	output logic             coreRxd,
	output logic             shiftDataOut,
	input  wire logic        uart2Txd,
	output logic             uart2Rxd,
	// Transceiver and GPIO pins
	input  wire logic        linRxd,
	output logic             linTxd,
	input  wire logic        gpioTxIn,
	output logic             gpioTxOut,
	output logic             gpioTxOe,
	input  wire logic        gpioRxIn,
	output logic             gpioRxOut,
	output logic             gpioRxOe,
	input  wire logic        uart2RxA,
	input  wire logic        uart2RxB,
	output logic             uart2TxA,
	output logic             uart2TxB,
	// Interrupt requests
	output logic             uartIrq,
	output logic             timerIrq,
	output logic             synchIrq
);
	typedef struct packed {
		logic                 ack;
		logic [31:0]          rdata;
		lin_autobaud_pkg::ctrl_t ctrl;
		logic                 break_seen_flag;
		logic                 sDone;
		logic                 sErr;
		logic                 extF;
		logic                 rxF;
		logic                 txF;
		logic                 rxIe;
		logic                 txIe;
		logic [15:0]          tCnt;
		logic [15:0]          capVal;
		logic [4:0]           meta;
		logic [4:0]           syn;
		logic                 prevLin;
		lin_autobaud_pkg::det_t det;
		logic [5:0]           pre;
		logic                 samp;
		logic [11:0]          bkLen;
		logic [11:0]          bitLen;
		logic [11:0]          segLen;
		logic [3:0]           segNum;
		logic [19:0]          domCnt;
		logic                 domTo;
		logic                 linTx;
		logic                 gTxOut;
		logic                 gTxOe;
		logic                 gRxOut;
		logic                 gRxOe;
		logic                 uRx;
		logic                 shOut;
		logic                 u2Rx;
		logic                 u2TxA;
		logic                 u2TxB;
	} state_t;

	state_t s;
	state_t next_s;
	logic        wrReq;
	logic        linFall;
	logic        tick;
	logic        serialTx;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic [15:0] ratioLen;
	logic [11:0] tol;
	logic [11:0] diff;
	logic        clrBrk;

	assign wrReq    = wb_cyc_i & wb_stb_i & wb_we_i & ~s.ack;
	assign wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata    = wb_dat_i[15:0];
	assign linFall  = s.prevLin & ~s.syn[0];
	assign tick     = (s.pre == 6'((`SAMPLE_BASE << s.ctrl.breakRangeSelect) - 7'h01)); // [RULE23]
	assign ratioLen = 16'(`BREAK_RATIO * {4'h0, s.segLen});
	assign tol      = s.bitLen >> 2;
	assign diff     = (s.segLen > s.bitLen) ? (s.segLen - s.bitLen) : (s.bitLen - s.segLen);
	assign clrBrk   = wrReq && wb_adr_i == `OFS_FLAG_CLEAR && wb_sel_i[0] && wb_dat_i[`ST_BREAK];
	// Mode 0 puts the shift clock on the transmit line
	assign serialTx = (s.ctrl.mode == `MODE_SHIFT) ? shiftClk : coreTxd; // [RULE14] [RULE15]

	always_comb begin
		next_s = s;
		// Pin synchronisers: second stage is the only reader of the first
		next_s.meta = {uart2RxB, uart2RxA, gpioRxIn, gpioTxIn, linRxd};
		next_s.syn = s.meta;
		next_s.prevLin = s.syn[0];
		// Bus slave: one wait state, ack drops the cycle after it rose
		next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
		next_s.rdata = 32'h00000000;
		if (wb_cyc_i && wb_stb_i && !s.ack && !wb_we_i) begin
			case (wb_adr_i)
				`OFS_CTRL: next_s.rdata = {20'h00000, s.ctrl};
				`OFS_STATUS: next_s.rdata = {26'h0000000, s.txF, s.rxF, s.extF, s.sErr, s.sDone, s.break_seen_flag};
				`OFS_TIMER: next_s.rdata = {16'h0000, s.tCnt};
				`OFS_CAPTURE: next_s.rdata = {16'h0000, s.capVal};
				`OFS_IRQ_EN: next_s.rdata = {30'h00000000, s.txIe, s.rxIe};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		// Timer: software writes win over counting; a stopped capture timer waits for an edge
		if (s.ctrl.timerRun)
			next_s.tCnt = s.tCnt + 16'h0001;
		if (linFall && s.ctrl.timerCapMode) begin
			if (s.ctrl.timerRun)
				next_s.capVal = s.tCnt; // [RULE7] [RULE11]
			else
				next_s.ctrl.timerRun = 1'b1; // [RULE2] [RULE4] [RULE6]
		end
		if (wrReq && wb_adr_i == `OFS_CTRL)
			next_s.ctrl = lin_autobaud_pkg::ctrl_t'((s.ctrl & ~wmask[11:0]) | (wdata[11:0] & wmask[11:0]));
		if (wrReq && wb_adr_i == `OFS_TIMER)
			next_s.tCnt = (s.tCnt & ~wmask) | (wdata & wmask);
		if (wrReq && wb_adr_i == `OFS_IRQ_EN && wb_sel_i[0]) begin
			next_s.rxIe = wdata[`IEN_RX];
			next_s.txIe = wdata[`IEN_TX];
		end
		// Sticky flags: write-one clears, a set in the same cycle wins
		if (wrReq && wb_adr_i == `OFS_FLAG_CLEAR && wb_sel_i[0]) begin
			next_s.break_seen_flag = s.break_seen_flag & ~wdata[`ST_BREAK]; // [RULE24]
			next_s.sDone = s.sDone & ~wdata[`ST_SYNC_DONE];
			next_s.sErr = s.sErr & ~wdata[`ST_SYNC_ERR];
			next_s.extF = s.extF & ~wdata[`ST_TIMER_EXT];
			next_s.rxF = s.rxF & ~wdata[`ST_RX_DONE];
			next_s.txF = s.txF & ~wdata[`ST_TX_DONE];
		end
		if (linFall && s.ctrl.timerCapMode && s.ctrl.timerExtIrqEn)
			next_s.extF = 1'b1; // [RULE4]
		if (rxDoneEvt)
			next_s.rxF = 1'b1; // [RULE20]
		if (txDoneEvt)
			next_s.txF = 1'b1; // [RULE20]
		// Break and synch detector on the sampled line
		next_s.pre = tick ? 6'h00 : s.pre + 6'h01;
		if (tick) begin
			next_s.samp = s.syn[0];
			case (s.det)
				lin_autobaud_pkg::D_IDLE: begin
					if (s.samp && !s.syn[0]) begin
						next_s.det = lin_autobaud_pkg::D_BREAK;
						next_s.bkLen = 12'h001;
					end
				end
				lin_autobaud_pkg::D_BREAK: begin
					if (s.syn[0])
						next_s.det = lin_autobaud_pkg::D_DELIM;
					else if (s.bkLen == `BREAK_CNT_MAX) begin
						next_s.sErr = 1'b1; // [RULE23]
						next_s.det = lin_autobaud_pkg::D_WAIT;
					end else
						next_s.bkLen = s.bkLen + 12'h001;
				end
				lin_autobaud_pkg::D_DELIM: begin
					if (!s.syn[0]) begin
						next_s.det = lin_autobaud_pkg::D_SEG;
						next_s.segLen = 12'h001;
						next_s.segNum = 4'h0;
					end
				end
				lin_autobaud_pkg::D_SEG: begin
					if (s.syn[0] != s.samp) begin
						next_s.segLen = 12'h001;
						next_s.segNum = s.segNum + 4'h1;
						if (s.segNum == 4'h0) begin
							next_s.bitLen = s.segLen;
							if ({4'h0, s.bkLen} >= ratioLen)
								next_s.break_seen_flag = 1'b1; // [RULE8]
						end else if (diff > tol) begin
							next_s.sErr = 1'b1; // [RULE12]
							next_s.det = lin_autobaud_pkg::D_WAIT;
						end else if (s.segNum == `SYNC_LAST_SEG) begin
							next_s.sDone = 1'b1; // [RULE9]
							next_s.det = lin_autobaud_pkg::D_IDLE;
						end
					end else if (s.segLen == `BREAK_CNT_MAX) begin
						next_s.sErr = 1'b1; // [RULE12]
						next_s.det = lin_autobaud_pkg::D_WAIT;
					end else
						next_s.segLen = s.segLen + 12'h001;
				end
				lin_autobaud_pkg::D_WAIT: begin
					if (s.syn[0])
						next_s.det = lin_autobaud_pkg::D_IDLE;
				end
				default: next_s.det = lin_autobaud_pkg::D_IDLE;
			endcase
		end
		// Held idle while software pulses the reset bit
		if (s.ctrl.breakLogicReset) begin
			next_s.det = lin_autobaud_pkg::D_IDLE;
			next_s.samp = 1'b1;
			next_s.pre = 6'h00;
		end
		// Dominant timeout on the GPIO transmit input in standalone routing
		if (!s.ctrl.txDisconnect || s.syn[1]) begin
			next_s.domCnt = 20'h00000;
			next_s.domTo = 1'b0;
		end else if (s.domCnt >= 20'(DOM_TIMEOUT_CYC)) begin
			next_s.domTo = 1'b1; // [RULE19]
		end else
			next_s.domCnt = s.domCnt + 20'h00001;
		// Pin routing matrix
		next_s.shOut = (s.ctrl.mode == `MODE_SHIFT) ? shiftData : 1'b1; // [RULE14]
		if (s.ctrl.txDisconnect) begin
			next_s.linTx = s.domTo | s.syn[1]; // [RULE17] [RULE19]
			next_s.uRx = s.syn[0];
			next_s.gTxOut = 1'b1;
			next_s.gTxOe = 1'b0;
			next_s.gRxOut = s.syn[0];
			next_s.gRxOe = 1'b1;
		end else if (s.ctrl.rxSourceSel) begin
			next_s.linTx = serialTx; // [RULE18]
			next_s.uRx = s.syn[2];
			next_s.gTxOut = serialTx;
			next_s.gTxOe = 1'b1;
			next_s.gRxOut = 1'b1;
			next_s.gRxOe = 1'b0;
		end else begin
			next_s.linTx = serialTx; // [RULE16]
			next_s.uRx = s.syn[0];
			next_s.gTxOut = serialTx;
			next_s.gTxOe = s.ctrl.monEn;
			next_s.gRxOut = s.syn[0];
			next_s.gRxOe = s.ctrl.monEn;
		end
		next_s.u2Rx = s.ctrl.uart2PinSel ? s.syn[4] : s.syn[3]; // [RULE21]
		next_s.u2TxA = s.ctrl.uart2PinSel ? 1'b1 : uart2Txd;
		next_s.u2TxB = s.ctrl.uart2PinSel ? uart2Txd : 1'b1;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.ctrl <= `CTRL_RESET; // [RULE25]
			s.meta <= 5'h1F;
			s.syn <= 5'h1F;
			s.prevLin <= 1'b1;
			s.samp <= 1'b1;
			s.linTx <= 1'b1;
			s.gTxOut <= 1'b1;
			s.gRxOut <= 1'b1;
			s.uRx <= 1'b1;
			s.shOut <= 1'b1;
			s.u2Rx <= 1'b1;
			s.u2TxA <= 1'b1;
			s.u2TxB <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
	assign wb_dat_o     = s.rdata;
	assign wb_ack_o     = s.ack;
	assign coreRxd      = s.uRx;
	assign shiftDataOut = s.shOut;
	assign uart2Rxd     = s.u2Rx;
	assign linTxd       = s.linTx;
	assign gpioTxOut    = s.gTxOut;
	assign gpioTxOe     = s.gTxOe;
	assign gpioRxOut    = s.gRxOut;
	assign gpioRxOe     = s.gRxOe;
	assign uart2TxA     = s.u2TxA;
	assign uart2TxB     = s.u2TxB;
	assign uartIrq      = (s.rxF & s.rxIe) | (s.txF & s.txIe); // [RULE20]
	assign timerIrq     = s.extF;
	assign synchIrq     = s.sDone | s.sErr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_flag_sticky: assert property (s.break_seen_flag && !clrBrk |=> s.break_seen_flag) else $error("break flag lost"); // [RULE24]
	chk_timer_start: assert property (linFall && s.ctrl.timerCapMode && !s.ctrl.timerRun && !wrReq
		|=> s.ctrl.timerRun ##1 s.tCnt == $past(s.tCnt) + 16'h0001) else $error("timer not started"); // [RULE6]
	chk_capture_copy: assert property (linFall && s.ctrl.timerCapMode && s.ctrl.timerRun
		|=> s.capVal == $past(s.tCnt)) else $error("capture missed"); // [RULE7]
	chk_ext_event: assert property (linFall && s.ctrl.timerCapMode && s.ctrl.timerExtIrqEn
		|=> timerIrq) else $error("timer event flag missing"); // [RULE4]
	chk_done_excl: assert property ($rose(s.sDone) |-> !$rose(s.sErr)) else $error("done and error together"); // [RULE12]
	chk_route_standalone: assert property (s.ctrl.txDisconnect && !s.domTo && !next_s.domTo
		|=> linTxd == $past(s.syn[1]) && gpioRxOe && !gpioTxOe) else $error("standalone routing wrong"); // [RULE17]
	chk_route_gpio: assert property (s.ctrl.rxSourceSel && !s.ctrl.txDisconnect
		|=> coreRxd == $past(s.syn[2]) && gpioTxOe && linTxd == gpioTxOut) else $error("gpio routing wrong"); // [RULE18]
	chk_route_lin: assert property (!s.ctrl.rxSourceSel && !s.ctrl.txDisconnect
		|=> coreRxd == $past(s.syn[0])) else $error("lin routing wrong"); // [RULE16]
	chk_dom_drop: assert property (s.domTo && s.ctrl.txDisconnect |=> linTxd) else $error("dominant timeout ignored"); // [RULE19]
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
	cov_synch_done: cover property ($rose(s.sDone) && s.break_seen_flag);
	cov_synch_err: cover property ($rose(s.sErr));
	cov_dom_timeout: cover property ($rose(s.domTo));
endmodule

// ==== lin_autobaud_defines.svh ====
// Register offsets, reset values and timing counts of the LIN serial front end
`ifndef LIN_AUTOBAUD_DEFINES_SVH
`define LIN_AUTOBAUD_DEFINES_SVH
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_FLAG_CLEAR 8'h08
`define OFS_TIMER      8'h0C
`define OFS_CAPTURE    8'h10
`define OFS_IRQ_EN     8'h14
`define CTRL_RESET     12'h000
`define ST_BREAK       0
`define ST_SYNC_DONE   1
`define ST_SYNC_ERR    2
`define ST_TIMER_EXT   3
`define ST_RX_DONE     4
`define ST_TX_DONE     5
`define IEN_RX         0
`define IEN_TX         1
`define CLK_MHZ        10
`define DOM_TIMEOUT_US 10000
`define DOM_TIMEOUT_CYC (`DOM_TIMEOUT_US * `CLK_MHZ)
`define SAMPLE_BASE    7'h08
`define BREAK_CNT_MAX  12'hFFF
`define BREAK_RATIO    16'h000B
`define SYNC_LAST_SEG  4'h8
`define MODE_SHIFT     2'h0
`endif

// ==== lin_autobaud_pkg.sv ====
// Types shared by the LIN serial front end
package lin_autobaud_pkg;
	typedef struct packed {
		logic       monEn;
		logic [1:0] mode;
		logic       uart2PinSel;
		logic       txDisconnect;
		logic       rxSourceSel;
		logic       timerExtIrqEn;
		logic       timerCapMode;
		logic       timerRun;
		logic       breakLogicReset;
		logic [1:0] breakRangeSelect;
	} ctrl_t;
	typedef enum logic [2:0] {
		D_IDLE  = 3'h0,
		D_BREAK = 3'h1,
		D_DELIM = 3'h2,
		D_SEG   = 3'h3,
		D_WAIT  = 3'h4
	} det_t;
endpackage

// ==== lin_master_model.sv ====
// LIN master model driving the transceiver receive line with break and synch headers
module lin_master_model (
	// Clock
	input  wire logic clk,
	// Line as seen through the transceiver, recessive high
	output logic      linRxd
);
	timeunit 1ns;
	timeprecision 1ns;

	initial linRxd = 1'b1;

	task automatic hold(input logic lvl, input int cyc);
		linRxd <= lvl;
		repeat (cyc) @(posedge clk);
	endtask

	// Bit bad is stretched to two bit times to corrupt the synch byte; 10 leaves it intact
	task automatic sendHeader(input int break_seen_flag, input int bitT, input int bad);
		logic [9:0] frame;
		frame = {1'b1, 8'h55, 1'b0};
		hold(1'b1, 2 * bitT);
		hold(1'b0, break_seen_flag * bitT);
		hold(1'b1, bitT);
		for (int i = 0; i < 10; i++) begin
			hold(frame[i], (i == bad) ? 2 * bitT : bitT);
		end
		hold(1'b1, 2 * bitT);
	endtask
endmodule

// ==== lin_autobaud_uart_routing_test.sv ====
// Self-checking bench of the LIN serial front end
`include "lin_autobaud_defines.svh"
module lin_autobaud_uart_routing_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DOM = 20;
	localparam int BIT_T = 64;

	logic        clk = 1'b0, rstn = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'hF;
	logic [31:0] wbWdat = 32'h0, wbRdat, rdData;
	logic        coreTxd = 1'b1, shiftClk = 1'b1, shiftData = 1'b1, rxDoneEvt = 1'b0, txDoneEvt = 1'b0;
	logic        uart2Txd = 1'b1, gpioTxIn = 1'b1, gpioRxIn = 1'b1, uart2RxA = 1'b1, uart2RxB = 1'b1;
	logic        coreRxd, shiftDataOut, uart2Rxd, linRxd, linTxd, gpioTxOut, gpioTxOe, gpioRxOut, gpioRxOe;
	logic        uart2TxA, uart2TxB, uartIrq, timerIrq, synchIrq;
	logic [11:0] ctl;
	logic [9:0]  e;
	logic [11:0] corner [4] = '{12'h000, 12'h0C0, 12'h240, 12'hB00};
	int          seed = 75206, failCount = 0, checksDone = 0, cycles = 0;

	lin_autobaud_uart_routing #(.DOM_TIMEOUT_CYC(DOM)) i_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbWdat),
		.wb_dat_o(wbRdat), .wb_ack_o(wbAck), .coreTxd(coreTxd), .shiftClk(shiftClk), .shiftData(shiftData),
		.rxDoneEvt(rxDoneEvt), .txDoneEvt(txDoneEvt), .coreRxd(coreRxd), .shiftDataOut(shiftDataOut),
		.uart2Txd(uart2Txd), .uart2Rxd(uart2Rxd), .linRxd(linRxd), .linTxd(linTxd), .gpioTxIn(gpioTxIn),
		.gpioTxOut(gpioTxOut), .gpioTxOe(gpioTxOe), .gpioRxIn(gpioRxIn), .gpioRxOut(gpioRxOut),
		.gpioRxOe(gpioRxOe), .uart2RxA(uart2RxA), .uart2RxB(uart2RxB), .uart2TxA(uart2TxA),
		.uart2TxB(uart2TxB), .uartIrq(uartIrq), .timerIrq(timerIrq), .synchIrq(synchIrq));
	lin_master_model i_master (.clk(clk), .linRxd(linRxd));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic conclude();
		$display("Checks made: %0d, mismatches: %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failCount++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wbX(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbWdat <= wd;
		wbSel <= sel;
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		rdData = wbRdat;
		if (n == 20) check("bus ack", 32'h0, 32'h1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wbW(input logic [7:0] a, input logic [31:0] d);
		wbX(1'b1, a, d, 4'hF);
	endtask

	task automatic wbR(input logic [7:0] a);
		wbX(1'b0, a, 32'h0, 4'hF);
	endtask

	task automatic waitHigh(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	// Pin image {linTxd, coreRxd, shiftDataOut, txOe, rxOe, txOut, rxOut, uart2Rxd, uart2TxA, uart2TxB}
	function automatic logic [9:0] expPins(logic [11:0] c);
		logic tx;
		logic [9:0] r;
		tx = (c[10:9] == `MODE_SHIFT) ? shiftClk : coreTxd;
		r[9] = c[7] ? gpioTxIn : tx;
		r[8] = (c[6] && !c[7]) ? gpioRxIn : linRxd;
		r[7] = (c[10:9] == `MODE_SHIFT) ? shiftData : 1'b1;
		r[6] = !c[7] && (c[6] || c[11]);
		r[5] = c[7] || (!c[6] && c[11]);
		r[4] = tx;
		r[3] = linRxd;
		r[2] = c[8] ? uart2RxB : uart2RxA;
		r[1] = c[8] ? 1'b1 : uart2Txd;
		r[0] = c[8] ? uart2Txd : 1'b1;
		return r;
	endfunction

	task automatic runHeader(input int break_seen_flag, input int bad, input logic [2:0] exp);
		// Range 0 samples every 8 clocks, fine for a 64-clock bit
		wbW(`OFS_CTRL, 32'h234);
		wbW(`OFS_CTRL, 32'h230);
		wbW(`OFS_FLAG_CLEAR, 32'h3F);
		fork
			i_master.sendHeader(break_seen_flag, BIT_T, bad);
		join_none
		waitHigh(timerIrq, 300);
		check("timer event", timerIrq, 1);
		wbW(`OFS_CTRL, 32'h210);
		wbW(`OFS_TIMER, 32'h0);
		wbW(`OFS_FLAG_CLEAR, 32'h8);
		wbR(`OFS_TIMER);
		check("timer cleared", rdData, 0);
		waitHigh(synchIrq, 3000);
		check("synch irq", synchIrq, 1);
		wbR(`OFS_STATUS);
		check("detect status", rdData, {28'h0, 1'b0, exp});
		wbR(`OFS_CAPTURE);
		if (exp[1]) check("capture", 32'(rdData[15:0] >= 8 * BIT_T - 4 && rdData[15:0] <= 8 * BIT_T + 4), 1);
		wbW(`OFS_FLAG_CLEAR, 32'hF);
		wbR(`OFS_STATUS);
		check("flags cleared", rdData, 0);
		wait fork;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wbR(`OFS_CTRL);
		check("ctrl reset", rdData, 0);
		wbR(`OFS_STATUS);
		check("status reset", rdData, 0);
		wbW(8'h40, 32'hFFFF);
		wbR(8'h40);
		check("unmapped", rdData, 0);
		wbX(1'b1, `OFS_CTRL, 32'hFFFF, 4'h1);
		wbR(`OFS_CTRL);
		check("ctrl low lane", rdData, 32'hFF);
		for (int i = 0; i < 16; i++) begin
			ctl = (i < 4) ? corner[i] : 12'($random(seed)) & 12'hFC0;
			coreTxd <= 1'($random(seed));
			shiftClk <= 1'($random(seed));
			shiftData <= 1'($random(seed));
			uart2Txd <= 1'($random(seed));
			gpioRxIn <= 1'($random(seed));
			uart2RxA <= 1'($random(seed));
			uart2RxB <= 1'($random(seed));
			gpioTxIn <= i[0] ? 1'($random(seed)) : 1'b1;
			wbW(`OFS_CTRL, {20'h0, ctl});
			repeat (4) @(posedge clk);
			e = expPins(ctl);
			check("pins", {linTxd, coreRxd, shiftDataOut, gpioTxOe, gpioRxOe, gpioTxOe ? gpioTxOut : e[4],
				gpioRxOe ? gpioRxOut : e[3], uart2Rxd, uart2TxA, uart2TxB}, e);
		end
		wbW(`OFS_CTRL, 32'h080);
		gpioTxIn <= 1'b0;
		repeat (DOM / 2) @(posedge clk);
		check("linTxd dominant", linTxd, 0);
		repeat (DOM) @(posedge clk);
		check("linTxd timeout", linTxd, 1);
		gpioTxIn <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wbW(`OFS_IRQ_EN, 32'(1 << k));
			rxDoneEvt <= (k == 0);
			txDoneEvt <= (k == 1);
			@(posedge clk);
			rxDoneEvt <= 1'b0;
			txDoneEvt <= 1'b0;
			@(posedge clk);
			check("irq on", uartIrq, 1);
			wbW(`OFS_IRQ_EN, 32'(2 >> k));
			check("irq masked", uartIrq, 0);
			wbR(`OFS_STATUS);
			check("done flag held", rdData, 32'(16 << k));
			wbW(`OFS_FLAG_CLEAR, 32'(16 << k));
			wbR(`OFS_STATUS);
			check("done flag cleared", rdData, 0);
		end
		runHeader(13, 10, 3'b011);
		runHeader(5, 10, 3'b010);
		runHeader(13, 1 + ($random(seed) & 7), 3'b101);
		conclude();
	end
endmodule
